// *** hdl/dasm_top.sv ***
// Purpose: dual converter control, result store, alarms and power-down
// Assumes: front end returns a result with a valid pulse after each start
// Notes: registers on the apb slave, results also on a side read port
//
// What this block does
// - two 12-bit converters, 1 MSPS each
// - simultaneous sampling of two external channels
// - mux selects 17 inputs plus sensors
// - per external channel unipolar, bipolar or differential, sensors always unipolar
// - external multiplexer mode on dedicated input
// - without user setup, scan all sensors
// - keep latest, maximum and minimum per channel
// - results readable any time on jtag port
// - threshold alarms for temperature and supplies
// - temperature limit triggers automatic power-down
`timescale 1ns/1ps
module dasm_top (
    input wire logic pclk, // clock, 200 MHz
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb write
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    output logic conv_start_a, // start pulse, converter a
    output logic conv_start_b, // start pulse, converter b
    output logic [4:0] mux_a_sel, // input mux select a
    output logic [4:0] mux_b_sel, // input mux select b
    output logic [1:0] sig_type_a, // signal type a
    output logic [1:0] sig_type_b, // signal type b
    output logic [4:0] ext_mux_addr, // external mux address
    output logic ext_mux_act, // external mux mode active
    input wire logic adc_a_valid, // result pulse a
    input wire logic [11:0] adc_a_data, // result code a
    input wire logic adc_b_valid, // result pulse b
    input wire logic [11:0] adc_b_data, // result code b
    input wire logic jtag_rd, // jtag read request
    input wire logic [6:0] jtag_addr, // channel and select
    output logic [11:0] jtag_rdata, // jtag read data
    output logic jtag_valid, // jtag data valid
    output logic alm_temp, // over-temperature alarm
    output logic alm_supply, // supply range alarm
    output logic pwr_down, // power-down request
    output logic irq // interrupt, high
);
    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] ch_type(input logic [33:0] t, input logic [4:0] ch);
        ch_type = ch < dasm_pkg::NEXT ? t[2*ch +: 2] : dasm_pkg::TY_UNI;
    endfunction

    function automatic logic [4:0] clamp_ch(input logic [4:0] ch);
        clamp_ch = ch < dasm_pkg::NCH ? ch : 5'h00;
    endfunction

    // ------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------
    logic [3:0] ctrl_r;
    logic [4:0] chan_a_r, chan_b_r;
    logic [33:0] type_r;
    logic [11:0] temp_hi_r, sup_hi_r, sup_lo_r, pd_lim_r;
    logic [dasm_pkg::NEV-1:0] status_r, status_nxt, mask_r, ev;
    logic [1:0] scan_r;
    logic [4:0] res_ch_a_r, res_ch_b_r;
    logic user_run_r;
    logic [1:0] sup_bad_r;
    logic tick;

    dasm_res_if rif ();

    dasm_tick u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    dasm_store u_store (
        .pclk(pclk),
        .presetn(presetn),
        .rif(rif)
    );

    // ------------------------------------------------------------
    // channel selection
    // ------------------------------------------------------------
    wire user = ctrl_r[dasm_pkg::C_USER];
    wire ext = user && ctrl_r[dasm_pkg::C_EXT];
    wire simul = user && ctrl_r[dasm_pkg::C_SIMUL] && !ext;
    wire [4:0] user_a = clamp_ch(chan_a_r);
    wire [4:0] user_b = clamp_ch(chan_b_r);
    wire [4:0] scan_ch = dasm_pkg::CH_TEMP + 5'(scan_r);
    // sensors are walked in turn until software takes over
    wire [4:0] sel_a = !user ? scan_ch : ext ? dasm_pkg::CH_DED : user_a;
    wire [4:0] log_a = !user ? scan_ch : user_a;
    wire [1:0] scan_nxt = scan_r == dasm_pkg::NSENS - 2'h1 ? 2'h0 : scan_r + 2'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_start_a <= 1'b0;
            conv_start_b <= 1'b0;
            mux_a_sel <= dasm_pkg::CH_TEMP;
            mux_b_sel <= 5'h00;
            sig_type_a <= dasm_pkg::TY_UNI;
            sig_type_b <= dasm_pkg::TY_UNI;
            ext_mux_addr <= 5'h00;
            ext_mux_act <= 1'b0;
            scan_r <= 2'h0;
            res_ch_a_r <= dasm_pkg::CH_TEMP;
            res_ch_b_r <= 5'h00;
            user_run_r <= 1'b0;
        end else begin
            conv_start_a <= tick;
            conv_start_b <= tick && simul;
            if (tick) begin
                mux_a_sel <= sel_a;
                sig_type_a <= ch_type(type_r, sel_a);
                ext_mux_act <= ext;
                ext_mux_addr <= ext ? user_a : 5'h00;
                res_ch_a_r <= log_a;
                user_run_r <= user;
                if (!user)
                    scan_r <= scan_nxt;
                if (simul) begin
                    mux_b_sel <= user_b;
                    sig_type_b <= ch_type(type_r, user_b);
                    res_ch_b_r <= user_b;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // result store and side read port
    // ------------------------------------------------------------
    assign rif.wr_a = adc_a_valid;
    assign rif.ch_a = res_ch_a_r;
    assign rif.code_a = adc_a_data;
    assign rif.wr_b = adc_b_valid;
    assign rif.ch_b = res_ch_b_r;
    assign rif.code_b = adc_b_data;
    assign rif.jt_ch = jtag_addr[6:2];
    assign rif.jt_sel = jtag_addr[1:0];

    // separate read port, so conversions never pause for a read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            jtag_rdata <= 12'h000;
            jtag_valid <= 1'b0;
        end else begin
            jtag_valid <= jtag_rd;
            if (jtag_rd)
                jtag_rdata <= rif.jt_data;
        end
    end

    // ------------------------------------------------------------
    // alarms and power-down
    // ------------------------------------------------------------
    wire temp_res = adc_a_valid && res_ch_a_r == dasm_pkg::CH_TEMP;
    wire vint_res = adc_a_valid && res_ch_a_r == dasm_pkg::CH_VINT;
    wire vaux_res = adc_a_valid && res_ch_a_r == dasm_pkg::CH_VAUX;
    wire sup_out = adc_a_data > sup_hi_r || adc_a_data < sup_lo_r;
    wire [1:0] sup_bad_nxt = {vaux_res ? sup_out : sup_bad_r[1], vint_res ? sup_out : sup_bad_r[0]};
    wire ot_nxt = temp_res ? adc_a_data > temp_hi_r : alm_temp;
    wire pd_hit = temp_res && ctrl_r[dasm_pkg::C_PDEN] && adc_a_data > pd_lim_r;

    // power-down stays latched: only a reset releases it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_bad_r <= 2'h0;
            alm_temp <= 1'b0;
            alm_supply <= 1'b0;
            pwr_down <= 1'b0;
        end else begin
            sup_bad_r <= sup_bad_nxt;
            alm_temp <= ot_nxt;
            alm_supply <= |sup_bad_nxt;
            if (pd_hit)
                pwr_down <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // apb slave, no wait state: read data is registered in the setup cycle
    // ------------------------------------------------------------
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire wr_acc = access && pwrite;
    wire res_hit = paddr[11:dasm_pkg::RES_PAGE_LSB] == dasm_pkg::RES_PAGE;
    wire [4:0] res_ch = paddr[dasm_pkg::RES_CH_LSB +: 5];
    wire [1:0] res_sel = paddr[dasm_pkg::RES_SEL_LSB +: 2];
    wire res_ok = res_hit && res_ch < dasm_pkg::NCH && res_sel != 2'h3;
    assign rif.rd_ch = res_ch;
    assign rif.rd_sel = res_sel;
    wire reg_ok = paddr <= dasm_pkg::A_STATE && paddr[1:0] == 2'h0;
    wire [31:0] state_word = {21'h0, user_run_r, ext_mux_act, res_ch_a_r, sup_bad_r, pwr_down, alm_temp};
    wire [31:0] rd_word =
        res_ok ? {20'h0, rif.rd_data} :
        paddr == dasm_pkg::A_CTRL ? {28'h0, ctrl_r} :
        paddr == dasm_pkg::A_CHSEL ? {19'h0, chan_b_r, 3'h0, chan_a_r} :
        paddr == dasm_pkg::A_TYPE_LO ? type_r[31:0] :
        paddr == dasm_pkg::A_TYPE_HI ? {30'h0, type_r[33:32]} :
        paddr == dasm_pkg::A_TEMP_HI ? {20'h0, temp_hi_r} :
        paddr == dasm_pkg::A_SUP_HI ? {20'h0, sup_hi_r} :
        paddr == dasm_pkg::A_SUP_LO ? {20'h0, sup_lo_r} :
        paddr == dasm_pkg::A_PD_LIM ? {20'h0, pd_lim_r} :
        paddr == dasm_pkg::A_STATUS ? {28'h0, status_r} :
        paddr == dasm_pkg::A_MASK ? {28'h0, mask_r} :
        paddr == dasm_pkg::A_STATE ? state_word : 32'h0;
    wire map_ok = res_ok ? !pwrite : reg_ok && !(pwrite && paddr >= dasm_pkg::A_STATUS
        && paddr != dasm_pkg::A_MASK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup && !map_ok;
            if (setup)
                prdata <= (map_ok && !pwrite) ? rd_word : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 4'h0;
            chan_a_r <= 5'h00;
            chan_b_r <= 5'h00;
            type_r <= 34'h0;
            temp_hi_r <= dasm_pkg::TEMP_HI_RST;
            sup_hi_r <= dasm_pkg::SUP_HI_RST;
            sup_lo_r <= dasm_pkg::SUP_LO_RST;
            pd_lim_r <= dasm_pkg::PD_LIM_RST;
            mask_r <= 4'h0;
        end else if (wr_acc && !pslverr) begin
            case (paddr)
                dasm_pkg::A_CTRL: ctrl_r <= pwdata[3:0];
                dasm_pkg::A_CHSEL: begin
                    chan_a_r <= pwdata[4:0];
                    chan_b_r <= pwdata[dasm_pkg::CHB_LSB +: 5];
                end
                dasm_pkg::A_TYPE_LO: type_r[31:0] <= pwdata;
                dasm_pkg::A_TYPE_HI: type_r[33:32] <= pwdata[1:0];
                dasm_pkg::A_TEMP_HI: temp_hi_r <= pwdata[11:0];
                dasm_pkg::A_SUP_HI: sup_hi_r <= pwdata[11:0];
                dasm_pkg::A_SUP_LO: sup_lo_r <= pwdata[11:0];
                dasm_pkg::A_PD_LIM: pd_lim_r <= pwdata[11:0];
                dasm_pkg::A_MASK: mask_r <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt status, cleared by reading, new events win
    // ------------------------------------------------------------
    wire rd_clr = access && !pwrite && paddr == dasm_pkg::A_STATUS;
    always_comb begin
        ev = '0;
        ev[dasm_pkg::EV_EOC] = adc_a_valid;
        ev[dasm_pkg::EV_OT] = ot_nxt && !alm_temp;
        ev[dasm_pkg::EV_SUP] = (|sup_bad_nxt) && !alm_supply;
        ev[dasm_pkg::EV_PD] = pd_hit && !pwr_down;
        // only the bits the read returned are cleared, an event after the setup edge survives
        status_nxt = (rd_clr ? status_r & ~prdata[dasm_pkg::NEV-1:0] : status_r) | ev;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= 4'h0;
            irq <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irq <= |(status_nxt & mask_r);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    conv_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_a |=> (!conv_start_a)[*8] ##0 (1 ##192 conv_start_a))
        else $error("conversion start not at the sample rate");
    simul_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_b |-> conv_start_a && mux_b_sel < dasm_pkg::NEXT)
        else $error("converter b started alone or on a sensor");
    mux_range_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_a |-> mux_a_sel < dasm_pkg::NCH)
        else $error("mux select out of range");
    type_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_a && !$past(tick && wr_acc) |-> sig_type_a == ch_type(type_r, mux_a_sel))
        else $error("signal type does not follow channel");
    ext_mux_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_a && ext_mux_act |-> mux_a_sel == dasm_pkg::CH_DED)
        else $error("external mux mode not on dedicated input");
    sensor_scan_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && !user |=> conv_start_a && mux_a_sel >= dasm_pkg::CH_TEMP && !conv_start_b)
        else $error("default scan left the sensors");
    jtag_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        jtag_rd |=> jtag_valid && jtag_rdata == $past(rif.jt_data))
        else $error("side read port did not answer");
    temp_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
        temp_res |=> alm_temp == ($past(adc_a_data) > $past(temp_hi_r)))
        else $error("temperature alarm wrong");
    power_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        pd_hit |=> pwr_down [*2])
        else $error("power-down not raised and held");
    pd_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(pwr_down) |-> $past(temp_res && ctrl_r[dasm_pkg::C_PDEN] && adc_a_data > pd_lim_r))
        else $error("power-down raised without a temperature over the limit");
    supply_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
        vint_res |=> sup_bad_r[0] == ($past(adc_a_data) > $past(sup_hi_r) || $past(adc_a_data) < $past(sup_lo_r)))
        else $error("supply alarm wrong");
    temp_only_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(alm_temp) |-> $past(temp_res))
        else $error("temperature alarm rose without a temperature result");
    irq_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> (status_r & $past(mask_r)) != '0)
        else $error("interrupt without an unmasked status bit");
    b_start_a: assert property (@(posedge pclk) disable iff (!presetn)
        tick && simul |=> conv_start_b && mux_b_sel == $past(user_b))
        else $error("converter b not started on its channel");
    b_type_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_b && !$past(tick && wr_acc) |-> sig_type_b == ch_type(type_r, mux_b_sel))
        else $error("signal type b does not follow channel");
    ext_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        conv_start_a && ext_mux_act |-> ext_mux_addr == res_ch_a_r)
        else $error("external result not filed under its address");
    mux_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tick |=> $stable(mux_a_sel) && $stable(sig_type_a))
        else $error("mux select moved between starts");
    jtag_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !jtag_rd |=> !jtag_valid)
        else $error("side read answered without request");
endmodule

// *** hdl/dasm_pkg.sv ***
// Purpose: constants and types of the dual converter sensor monitor
// Assumes: 200 MHz pclk, 32-bit register bus
// Notes: register offsets are byte addresses
package dasm_pkg;
    localparam int CODE_W = 12;
    localparam int CH_W = 5;
    localparam int NCH = 20;
    localparam int NEXT = 17;
    localparam logic [CH_W-1:0] CH_DED = 5'h10;
    localparam logic [CH_W-1:0] CH_TEMP = 5'h11;
    localparam logic [CH_W-1:0] CH_VINT = 5'h12;
    localparam logic [CH_W-1:0] CH_VAUX = 5'h13;
    localparam logic [1:0] NSENS = 2'h3;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int CONV_RATE_KSPS = 1000;
    localparam int CONV_CYC = 1000000000 / (CONV_RATE_KSPS * CLK_PERIOD_PS);
    localparam logic [CODE_W-1:0] CODE_LOW = 12'h000;
    localparam logic [CODE_W-1:0] CODE_HIGH = 12'hFFF;
    typedef enum logic [1:0] {TY_UNI, TY_BIP, TY_DIFF} dasm_type_t;
    typedef enum logic [1:0] {SEL_LAST, SEL_MAX, SEL_MIN} dasm_sel_t;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_CHSEL = 12'h004;
    localparam logic [11:0] A_TYPE_LO = 12'h008;
    localparam logic [11:0] A_TYPE_HI = 12'h00C;
    localparam logic [11:0] A_TEMP_HI = 12'h010;
    localparam logic [11:0] A_SUP_HI = 12'h014;
    localparam logic [11:0] A_SUP_LO = 12'h018;
    localparam logic [11:0] A_PD_LIM = 12'h01C;
    localparam logic [11:0] A_STATUS = 12'h020;
    localparam logic [11:0] A_MASK = 12'h024;
    localparam logic [11:0] A_STATE = 12'h028;
    localparam logic [2:0] RES_PAGE = 3'h2;
    localparam int RES_PAGE_LSB = 9;
    localparam int RES_CH_LSB = 4;
    localparam int RES_SEL_LSB = 2;
    localparam int C_USER = 0;
    localparam int C_SIMUL = 1;
    localparam int C_EXT = 2;
    localparam int C_PDEN = 3;
    localparam int CHB_LSB = 8;
    localparam int NEV = 4;
    localparam int EV_EOC = 0;
    localparam int EV_OT = 1;
    localparam int EV_SUP = 2;
    localparam int EV_PD = 3;
    localparam logic [CODE_W-1:0] TEMP_HI_RST = 12'hFFF;
    localparam logic [CODE_W-1:0] SUP_HI_RST = 12'hFFF;
    localparam logic [CODE_W-1:0] SUP_LO_RST = 12'h000;
    localparam logic [CODE_W-1:0] PD_LIM_RST = 12'hFFF;
endpackage

// *** hdl/dasm_res_if.sv ***
// Purpose: result store write and read ports
// Assumes: single pclk domain
// Notes: two write ports, two independent read ports
`timescale 1ns/1ps
interface dasm_res_if;
    logic wr_a;
    logic [dasm_pkg::CH_W-1:0] ch_a;
    logic [dasm_pkg::CODE_W-1:0] code_a;
    logic wr_b;
    logic [dasm_pkg::CH_W-1:0] ch_b;
    logic [dasm_pkg::CODE_W-1:0] code_b;
    logic [dasm_pkg::CH_W-1:0] rd_ch;
    logic [1:0] rd_sel;
    logic [dasm_pkg::CODE_W-1:0] rd_data;
    logic [dasm_pkg::CH_W-1:0] jt_ch;
    logic [1:0] jt_sel;
    logic [dasm_pkg::CODE_W-1:0] jt_data;
    modport ctl (output wr_a, ch_a, code_a, wr_b, ch_b, code_b, rd_ch, rd_sel, jt_ch, jt_sel,
        input rd_data, jt_data);
    modport store (input wr_a, ch_a, code_a, wr_b, ch_b, code_b, rd_ch, rd_sel, jt_ch, jt_sel,
        output rd_data, jt_data);
endinterface

// *** hdl/dasm_tick.sv ***
// Purpose: conversion rate divider
// Assumes: one pclk domain
// Notes: one-cycle pulse every DIV cycles
`timescale 1ns/1ps
module dasm_tick #(
    parameter int DIV = dasm_pkg::CONV_CYC
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    output logic tick // rate pulse
);
    logic [7:0] cnt_r;
    wire last = (cnt_r == 8'(DIV - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 8'h00;
            tick <= 1'b0;
        end else begin
            cnt_r <= last ? 8'h00 : cnt_r + 8'h01;
            tick <= last;
        end
    end
endmodule

// *** hdl/dasm_store.sv ***
// Purpose: latest, maximum and minimum result per channel
// Assumes: writes carry channel numbers below NCH
// Notes: port b wins the latest value when both hit one channel
`timescale 1ns/1ps
module dasm_store (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    dasm_res_if.store rif // write and read ports
);
    logic [dasm_pkg::CODE_W-1:0] last_r [dasm_pkg::NCH];
    logic [dasm_pkg::CODE_W-1:0] max_r [dasm_pkg::NCH];
    logic [dasm_pkg::CODE_W-1:0] min_r [dasm_pkg::NCH];

    function automatic logic [dasm_pkg::CODE_W-1:0] pick(input logic [dasm_pkg::CH_W-1:0] ch,
                                                        input logic [1:0] sel);
        pick = sel == dasm_pkg::SEL_MAX ? max_r[ch] : sel == dasm_pkg::SEL_MIN ? min_r[ch] : last_r[ch];
    endfunction

    assign rif.rd_data = pick(rif.rd_ch, rif.rd_sel);
    assign rif.jt_data = pick(rif.jt_ch, rif.jt_sel);

    for (genvar i = 0; i < dasm_pkg::NCH; i++) begin : g_ch
        wire hit_a = rif.wr_a && rif.ch_a == i;
        wire hit_b = rif.wr_b && rif.ch_b == i;
        wire [dasm_pkg::CODE_W-1:0] hi_a = (hit_a && rif.code_a > max_r[i]) ? rif.code_a : max_r[i];
        wire [dasm_pkg::CODE_W-1:0] lo_a = (hit_a && rif.code_a < min_r[i]) ? rif.code_a : min_r[i];
        wire [dasm_pkg::CODE_W-1:0] hi_nxt = (hit_b && rif.code_b > hi_a) ? rif.code_b : hi_a;
        wire [dasm_pkg::CODE_W-1:0] lo_nxt = (hit_b && rif.code_b < lo_a) ? rif.code_b : lo_a;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                last_r[i] <= dasm_pkg::CODE_LOW;
                max_r[i] <= dasm_pkg::CODE_LOW;
                min_r[i] <= dasm_pkg::CODE_HIGH;
            end else begin
                if (hit_b)
                    last_r[i] <= rif.code_b;
                else if (hit_a)
                    last_r[i] <= rif.code_a;
                max_r[i] <= hi_nxt;
                min_r[i] <= lo_nxt;
            end
        end
    end

    max_track_a: assert property (@(posedge pclk) disable iff (!presetn)
        rif.wr_a && !rif.wr_b |=> max_r[$past(rif.ch_a)] >= $past(rif.code_a)
            && min_r[$past(rif.ch_a)] <= $past(rif.code_a))
        else $error("min or max missed a new result");
endmodule

// *** verif/dasm_fe_lane.sv ***
// Purpose: converter front end stand-in, one lane
// Assumes: start pulses at least dly+2 cycles apart
// Notes: data toggles every cycle outside the valid pulse
`timescale 1ns/1ps
module dasm_fe_lane (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, low
    input wire logic start, // start pulse
    input wire logic [11:0] code, // code to return
    input wire logic [7:0] dly, // answer delay in cycles
    output logic valid, // result pulse
    output logic [11:0] data // result code
);
    logic [8:0] cnt_r;
    // released data never holds its last value, so a late sample cannot pass by luck
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            valid <= 1'b0;
            data <= 12'hA5A;
        end else begin
            valid <= 1'b0;
            data <= ~data;
            if (start) cnt_r <= {1'b0, dly} + 9'h1;
            else if (cnt_r != 9'h0) cnt_r <= cnt_r - 9'h1;
            if (cnt_r == 9'h1) begin
                valid <= 1'b1;
                data <= code;
            end
        end
    end
endmodule

// *** verif/tb_dasm_top.sv ***
// Purpose: bench for the dual converter monitor
// Assumes: apb answers within 50 cycles, starts come within 500
// Notes: two front end lanes stand in for the converters
`timescale 1ns/1ps
module tb_dasm_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, jtag_rd = 0;
    logic [11:0] paddr = '0, code_a = '0, code_b = '0, adc_a_data, adc_b_data, jtag_rdata;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, conv_start_a, conv_start_b, ext_mux_act, adc_a_valid, adc_b_valid, sb;
    logic [4:0] mux_a_sel, mux_b_sel, ext_mux_addr, sa, e;
    logic [1:0] sig_type_a, sig_type_b;
    logic [6:0] jtag_addr = '0;
    logic jtag_valid, alm_temp, alm_supply, pwr_down, irq;
    logic [7:0] dly = 8'h2;
    logic [11:0] ra [4] = '{dasm_pkg::A_TEMP_HI, dasm_pkg::A_SUP_HI, dasm_pkg::A_SUP_LO, dasm_pkg::A_PD_LIM};
    logic [31:0] rv [4] = '{32'hFFF, 32'hFFF, 32'h0, 32'hFFF};
    int n_fail = 0, samples_checked = 0, gap;
    initial forever #2.5 pclk = ~pclk;
    dasm_top dasm_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .conv_start_a, .conv_start_b, .mux_a_sel, .mux_b_sel, .sig_type_a, .sig_type_b,
        .ext_mux_addr, .ext_mux_act, .adc_a_valid, .adc_a_data, .adc_b_valid, .adc_b_data, .jtag_rd,
        .jtag_addr, .jtag_rdata, .jtag_valid, .alm_temp, .alm_supply, .pwr_down, .irq);
    dasm_fe_lane lane_a_i (.pclk(pclk), .presetn(presetn), .start(conv_start_a), .code(code_a), .dly(dly),
        .valid(adc_a_valid), .data(adc_a_data));
    dasm_fe_lane lane_b_i (.pclk(pclk), .presetn(presetn), .start(conv_start_b), .code(code_b), .dly(dly),
        .valid(adc_b_valid), .data(adc_b_data));
    task give_verdict;
        $display("compares %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin n_fail++; give_verdict; end
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d); chk(32'(err), 0);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] x);
        apb(0, a, 0); chk(rd, x);
    endtask
    // start edge is where selects and the b start are seen, before the next start moves them
    task wait_a;
        int n;
        n = 0;
        do begin @(posedge pclk); n++; end while (conv_start_a !== 1'b1 && n < 500);
        if (conv_start_a !== 1'b1) begin n_fail++; give_verdict; end
        gap = n; sa = mux_a_sel; sb = conv_start_b;
    endtask
    task run_a(input logic [11:0] c);
        code_a <= c; wait_a; repeat (dly + 4) @(posedge pclk);
    endtask
    task jt(input logic [4:0] ch, input logic [1:0] s, input logic [11:0] x);
        @(posedge pclk); jtag_rd <= 1; jtag_addr <= {ch, s};
        @(posedge pclk); jtag_rd <= 0;
        @(posedge pclk); chk(32'(jtag_valid), 1); chk(32'(jtag_rdata), 32'(x));
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        jt(dasm_pkg::CH_TEMP, 1, 12'h000);
        jt(dasm_pkg::CH_TEMP, 2, 12'hFFF);
        for (int i = 0; i < 4; i++) rdc(ra[i], rv[i]);
        rdc(12'h02C, 0); chk(32'(err), 1);
        apb(1, dasm_pkg::A_STATUS, 1); chk(32'(err), 1);
        wait_a;
        for (int i = 0; i < 3; i++) begin
            e = (sa == dasm_pkg::CH_VAUX) ? dasm_pkg::CH_TEMP : sa + 5'h1;
            wait_a;
            chk(32'(sa), 32'(e)); chk(32'(sa >= dasm_pkg::CH_TEMP), 1);
            chk(gap, dasm_pkg::CONV_CYC);
        end
        wr(dasm_pkg::A_CTRL, 1); wr(dasm_pkg::A_CHSEL, 3);
        run_a(12'h500);
        dly <= 8'd150;
        run_a(12'h200);
        dly <= 8'd2;
        run_a(12'h700);
        jt(3, 0, 12'h700); jt(3, 1, 12'h700); jt(3, 2, 12'h200);
        rdc(12'h434, 32'h700); rdc(12'h438, 32'h200);
        rdc(12'h43C, 0); chk(32'(err), 1);
        wr(dasm_pkg::A_TYPE_LO, 32'h40800); wr(dasm_pkg::A_CTRL, 3); wr(dasm_pkg::A_CHSEL, 32'h0905);
        code_b <= 12'h456;
        run_a(12'h123);
        chk(32'(sb), 1); chk(32'(mux_b_sel), 9); chk(32'(sig_type_a), 2);
        chk(32'(sig_type_b), 1);
        jt(9, 0, 12'h456); jt(5, 0, 12'h123);
        wr(dasm_pkg::A_CTRL, 5); wr(dasm_pkg::A_CHSEL, 7);
        run_a(12'h3C3);
        chk(32'(sa), 32'(dasm_pkg::CH_DED)); chk(32'(ext_mux_addr), 7); chk(32'(ext_mux_act), 1);
        jt(7, 0, 12'h3C3);
        wr(dasm_pkg::A_CTRL, 1); wr(dasm_pkg::A_CHSEL, 32'h14);
        run_a(12'h0);
        run_a(12'h0);
        chk(32'(sa), 0);
        wr(dasm_pkg::A_MASK, 0); wr(dasm_pkg::A_TEMP_HI, 32'h800); wr(dasm_pkg::A_CHSEL, 32'h11);
        run_a(12'h900);
        chk(32'(alm_temp), 1); chk(32'(irq), 0); chk(32'(pwr_down), 0);
        rdc(12'h510, 32'h900);
        wr(dasm_pkg::A_MASK, 2);
        repeat (3) @(posedge pclk);
        chk(32'(irq), 1);
        rdc(dasm_pkg::A_STATUS, 32'h3);
        repeat (3) @(posedge pclk);
        chk(32'(irq), 0);
        wr(dasm_pkg::A_SUP_HI, 32'h900); wr(dasm_pkg::A_CHSEL, 32'h12);
        run_a(12'hA00);
        chk(32'(alm_supply), 1);
        wr(dasm_pkg::A_PD_LIM, 32'hA00); wr(dasm_pkg::A_CTRL, 9); wr(dasm_pkg::A_CHSEL, 32'h11);
        run_a(12'hB00);
        chk(32'(pwr_down), 1);
        give_verdict;
    end
endmodule
